// File: hdl/reset_and_supply_monitor_ctrl.sv
// reset and supply supervisor with a classic wishbone register slave
// assumes analog comparators and the power-on detector drive async levels
// Function
// R01: hibernate keeps state and held outputs
// R02: only external reset pin leaves hibernate; the code leaves it on any system reset, software reset included
// R03: wakeup returns power mode to active
// R04: low reset pin holds reset, like power-on
// R05: reset pin works in sleep and hibernate
// R06: power-on reset pulse at least minimum width
// R07: power-on monitor off when supply stable
// R08: programmable low-voltage trip settings
// R09: fixed high-voltage trip, no setting
// R10: monitors only after power-on, active modes
// R11: firmware wakes periodically to check supplies
// R12: software reset bit resets like power-on
// R13: disable bit blocks software reset
// R14: unkicked watchdog causes system reset
// R15: watchdog enable sticky until power-on reset
// R16: watchdog runs only in active mode
// R17: status register records resets, cleared by power-on
// R18: system reset resets processor and peripherals
// R19: timewheel runs in sleep and wakes device
// R20: reset asserts async, releases synchronised
`timescale 1ns/1ps
`include "rsm_defines.svh"
module reset_and_supply_monitor_ctrl
	import rsm_pkg::*;
#(
	parameter int WAKE_CYC = `WAKE_CYCLES
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_B,
	input  wire logic        EXTERNAL_RESET_PIN_N,
	input  wire logic        SUPPLY_STABLE,
	input  wire logic        DIG_BELOW_TRIP,
	input  wire logic        ANA_BELOW_TRIP,
	input  wire logic        ANA_ABOVE_HIGH,
	output logic [3:0]       DIG_TRIP_SEL,
	output logic [3:0]       ANA_TRIP_SEL,
	output logic             POR_MON_EN,
	output logic             OSC_EN,
	output logic             MON_EN,
	output logic             SYS_RST_N,
	output logic             HOLD_OUTPUTS,
	output logic [1:0]       POWER_MODE,
	output logic             CPU_WAKE,
	output logic             DIGITAL_LOW_VOLTAGE_IRQ,
	output logic             ANALOG_LOW_VOLTAGE_IRQ,
	output logic             ANALOG_HIGH_VOLTAGE_IRQ,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	input  wire logic [3:0]  WB_SEL_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O
);
	// power-on domain: RST_B is the initial power-on reset request
	logic        external_reset_pin_n_s;
	logic [2:0]  cmp_s;
	logic        stable_s;
	logic        sys_req_n;
	logic        sys_rst_n;
	logic        software_reset_event_pulse_r;
	logic        watchdog_reset_event_pulse_r;
	logic        software_reset_event_dis_r;
	logic        wdt_en_r;
	logic [31:0] wdt_limit_r;
	logic [31:0] wdt_cnt_r;
	logic [31:0] ctw_period_r;
	logic [31:0] ctw_cnt_r;
	logic [3:0]  dtrip_r;
	logic [3:0]  atrip_r;
	logic [`STAT_W-1:0] status_r;
	logic [2:0]  irq_r;
	logic [7:0]  por_cnt_r;
	logic        por_ok_r;
	logic        mon_off_r;
	pmode_t      pmode_r;
	logic        external_reset_pin_n_prev_r;
	logic [31:0] wake_cnt_r;
	logic        ack_r;
	logic        wr_stb;
	logic        wdt_kick;
	logic        software_reset_event_hit;
	logic        wdt_hit;
	logic        sleep_like;

	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] clip_trip(input logic [3:0] v);
		return (v > `TRIP_MAX) ? `TRIP_MAX : v;
	endfunction

	bit_sync #(.W(1), .RST(1'b0)) u_external_reset_pin_n (
		.clk   (CORE_CLK),
		.rst_n (RST_B),
		.din   (EXTERNAL_RESET_PIN_N),
		.dout  (external_reset_pin_n_s)
	);

	bit_sync #(.W(4), .RST(4'h0)) u_cmp (
		.clk   (CORE_CLK),
		.rst_n (RST_B),
		.din   ({SUPPLY_STABLE, ANA_ABOVE_HIGH, ANA_BELOW_TRIP, DIG_BELOW_TRIP}),
		.dout  ({stable_s, cmp_s})
	);

	// power-on pulse stretched to the minimum width
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			por_cnt_r <= 8'h00;
			por_ok_r  <= 1'b0;
		end else if (!por_ok_r) begin
			por_cnt_r <= por_cnt_r + 8'h01;
			if (por_cnt_r >= 8'(`POR_MIN_CYCLES - 1) && stable_s) begin // R06
				por_ok_r <= 1'b1;
			end
		end
	end

	// monitor powered down once the digital supply is stable
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mon_off_r <= 1'b0;
		end else if (por_ok_r) begin
			mon_off_r <= 1'b1; // R07
		end
	end
	assign POR_MON_EN = !mon_off_r;
	assign OSC_EN     = stable_s; // R07

	// combined reset request: any source asserts at once
	assign sys_req_n = RST_B & external_reset_pin_n_s & por_ok_r & !software_reset_event_pulse_r & !watchdog_reset_event_pulse_r; // R04 R18

	rst_sync u_sys_rst (
		.clk       (CORE_CLK),
		.rst_in_n  (sys_req_n),
		.rst_out_n (sys_rst_n)
	); // R20
	assign SYS_RST_N = sys_rst_n; // R18

	// software reset request, one-cycle pulse kept outside the reset it causes
	assign software_reset_event_hit = wr_stb && WB_ADR_I == `ADR_SOFTWARE_RESET_EVENT && WB_SEL_I[0] && WB_DAT_I[0] &&
		!software_reset_event_dis_r; // R13
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			software_reset_event_pulse_r <= 1'b0;
		end else begin
			software_reset_event_pulse_r <= software_reset_event_hit; // R12
		end
	end

	// sticky watchdog enable, cleared only by power-on
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wdt_en_r <= 1'b0;
		end else if (wr_stb && WB_ADR_I == `ADR_CTRL && WB_SEL_I[0] &&
			WB_DAT_I[`CTRL_WDT_EN_BIT]) begin
			wdt_en_r <= 1'b1; // R15
		end
	end

	always_ff @(posedge CORE_CLK or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			software_reset_event_dis_r   <= 1'b0;
			wdt_limit_r  <= `WDT_RST_VAL;
			ctw_period_r <= `CTW_RST_VAL;
			dtrip_r      <= `TRIP_RST_VAL;
			atrip_r      <= `TRIP_RST_VAL;
		end else if (wr_stb) begin
			case (WB_ADR_I)
				`ADR_CTRL: begin
					if (WB_SEL_I[0]) begin
						software_reset_event_dis_r <= WB_DAT_I[`CTRL_SOFTWARE_RESET_EVENT_DIS_BIT]; // R13
					end
				end
				`ADR_WDT_CFG: wdt_limit_r  <= wmask(wdt_limit_r, WB_DAT_I, WB_SEL_I);
				`ADR_CTW_CFG: ctw_period_r <= wmask(ctw_period_r, WB_DAT_I, WB_SEL_I);
				`ADR_MON_CFG: begin
					if (WB_SEL_I[0]) begin
						dtrip_r <= clip_trip(WB_DAT_I[3:0]); // R08
					end
					if (WB_SEL_I[1]) begin
						atrip_r <= clip_trip(WB_DAT_I[11:8]); // R08
					end
				end
				default: ;
			endcase
		end
	end
	assign DIG_TRIP_SEL = dtrip_r; // R08
	assign ANA_TRIP_SEL = atrip_r; // R08

	// watchdog counts only in active mode
	assign wdt_kick = wr_stb && WB_ADR_I == `ADR_WDT_KICK;
	assign wdt_hit  = wdt_en_r && pmode_r == PM_ACTIVE && !wdt_kick &&
		wdt_cnt_r >= wdt_limit_r; // R14 R16
	always_ff @(posedge CORE_CLK or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			wdt_cnt_r <= 32'h00000000;
		end else if (wdt_kick) begin
			wdt_cnt_r <= 32'h00000000; // R14
		end else if (wdt_en_r && pmode_r == PM_ACTIVE && wdt_cnt_r < wdt_limit_r) begin
			wdt_cnt_r <= wdt_cnt_r + 32'h00000001; // R16
		end
	end

	// watchdog reset request, one cycle, survives the reset it causes
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			watchdog_reset_event_pulse_r <= 1'b0;
		end else begin
			watchdog_reset_event_pulse_r <= wdt_hit; // R14
		end
	end

	// power mode: hibernate left only by a system reset; timewheel wakes sleep
	assign sleep_like = (pmode_r == PM_SLEEP) || (pmode_r == PM_HIBERNATE);
	always_ff @(posedge CORE_CLK or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			pmode_r    <= PM_ACTIVE; // R03 R05
			ctw_cnt_r  <= 32'h00000000;
			wake_cnt_r <= 32'h00000000;
		end else begin
			if (pmode_r == PM_SLEEP) begin
				if (ctw_cnt_r >= ctw_period_r) begin
					ctw_cnt_r  <= 32'h00000000;
					wake_cnt_r <= 32'h00000001; // R19
				end else begin
					ctw_cnt_r <= ctw_cnt_r + 32'h00000001; // R19
				end
			end else begin
				ctw_cnt_r <= 32'h00000000;
			end
			if (wake_cnt_r != 32'h00000000) begin
				if (wake_cnt_r >= 32'(WAKE_CYC)) begin
					wake_cnt_r <= 32'h00000000;
					pmode_r    <= PM_ACTIVE; // R03
				end else begin
					wake_cnt_r <= wake_cnt_r + 32'h00000001;
				end
			end else if (wr_stb && WB_ADR_I == `ADR_PMODE && WB_SEL_I[0] &&
				pmode_r != PM_HIBERNATE) begin // R02
				pmode_r <= pmode_t'(WB_DAT_I[1:0]);
			end
		end
	end
	assign POWER_MODE   = pmode_r;
	assign HOLD_OUTPUTS = (pmode_r == PM_HIBERNATE); // R01
	assign CPU_WAKE     = !sleep_like;

	// monitors and their interrupt flags
	assign MON_EN = por_ok_r && !sleep_like; // R10
	always_ff @(posedge CORE_CLK or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			irq_r <= 3'h0;
		end else if (MON_EN) begin // R10
			irq_r <= cmp_s; // R08 R09
		end else begin
			irq_r <= 3'h0;
		end
	end
	assign DIGITAL_LOW_VOLTAGE_IRQ = irq_r[0];
	assign ANALOG_LOW_VOLTAGE_IRQ  = irq_r[1];
	assign ANALOG_HIGH_VOLTAGE_IRQ = irq_r[2]; // R09

	// reset status, survives system reset, cleared by power-on; set wins
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			status_r    <= `STAT_W'(1); // R17
			external_reset_pin_n_prev_r <= 1'b0;
		end else begin
			if (wr_stb && WB_ADR_I == `ADR_STATUS && WB_SEL_I[0]) begin
				status_r <= status_r & ~WB_DAT_I[`STAT_W-1:0];
			end
			external_reset_pin_n_prev_r <= external_reset_pin_n_s;
			if (external_reset_pin_n_prev_r && !external_reset_pin_n_s) begin
				status_r[`STAT_EXTERNAL_RESET_PIN_N_BIT] <= 1'b1; // R17
			end
			if (software_reset_event_pulse_r) begin
				status_r[`STAT_SOFTWARE_RESET_EVENT_BIT] <= 1'b1; // R17
			end
			if (watchdog_reset_event_pulse_r) begin
				status_r[`STAT_WATCHDOG_RESET_EVENT_BIT] <= 1'b1; // R17
			end
			if (irq_r[0]) begin
				status_r[`STAT_DIGITAL_LOW_VOLTAGE_IRQ_BIT] <= 1'b1;
			end
			if (irq_r[1]) begin
				status_r[`STAT_ANALOG_LOW_VOLTAGE_IRQ_BIT] <= 1'b1;
			end
			if (irq_r[2]) begin
				status_r[`STAT_ANALOG_HIGH_VOLTAGE_IRQ_BIT] <= 1'b1;
			end
		end
	end

	// wishbone slave: one wait state, ack for one cycle
	assign wr_stb = WB_CYC_I && WB_STB_I && WB_WE_I && ack_r;
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ack_r    <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			ack_r <= WB_CYC_I && WB_STB_I && !ack_r;
			case (WB_ADR_I)
				`ADR_CTRL:     WB_DAT_O <= {30'h0, wdt_en_r, software_reset_event_dis_r};
				`ADR_WDT_CFG:  WB_DAT_O <= wdt_limit_r;
				`ADR_WDT_KICK: WB_DAT_O <= wdt_cnt_r;
				`ADR_STATUS:   WB_DAT_O <= {25'h0, status_r};
				`ADR_MON_CFG:  WB_DAT_O <= {20'h0, atrip_r, 4'h0, dtrip_r};
				`ADR_PMODE:    WB_DAT_O <= {30'h0, pmode_r};
				`ADR_CTW_CFG:  WB_DAT_O <= ctw_period_r;
				default:       WB_DAT_O <= 32'h00000000;
			endcase
		end
	end
	assign WB_ACK_O = ack_r;
endmodule // reset_and_supply_monitor_ctrl

// File: hdl/rsm_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes a 25 MHz core clock and a 32-bit classic wishbone bus
`ifndef RSM_DEFINES_SVH
`define RSM_DEFINES_SVH

`define CLK_PERIOD_PS        40000
`define POR_MIN_WIDTH_PS     100000
`define POR_MIN_CYCLES       ((`POR_MIN_WIDTH_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_TIME_NS         125000
`define WAKE_CYCLES          ((`WAKE_TIME_NS * 1000) / `CLK_PERIOD_PS)

`define ADR_CTRL             8'h00
`define ADR_SOFTWARE_RESET_EVENT             8'h04
`define ADR_WDT_CFG          8'h08
`define ADR_WDT_KICK         8'h0C
`define ADR_STATUS           8'h10
`define ADR_MON_CFG          8'h14
`define ADR_PMODE            8'h18
`define ADR_CTW_CFG          8'h1C

`define CTRL_SOFTWARE_RESET_EVENT_DIS_BIT    0
`define CTRL_WDT_EN_BIT      1
`define STAT_POR_BIT         0
`define STAT_EXTERNAL_RESET_PIN_N_BIT        1
`define STAT_SOFTWARE_RESET_EVENT_BIT        2
`define STAT_WATCHDOG_RESET_EVENT_BIT        3
`define STAT_DIGITAL_LOW_VOLTAGE_IRQ_BIT        4
`define STAT_ANALOG_LOW_VOLTAGE_IRQ_BIT        5
`define STAT_ANALOG_HIGH_VOLTAGE_IRQ_BIT        6
`define STAT_W               7

`define WDT_RST_VAL          32'h0000FFFF
`define CTW_RST_VAL          32'h0000FFFF
`define TRIP_RST_VAL         4'h0
`define TRIP_LVD             4'h0
`define TRIP_MAX             4'hC

`endif

// File: hdl/rsm_pkg.sv
// types shared by the reset and supply monitor files
package rsm_pkg;
	typedef enum logic [1:0] {
		PM_ACTIVE,
		PM_ALT_ACTIVE,
		PM_SLEEP,
		PM_HIBERNATE
	} pmode_t;
endpackage

// File: hdl/rst_sync.sv
// two-stage reset synchronizer: asserts at once, releases on the clock
// assumes rst_in_n is an asynchronous active-low request
`timescale 1ns/1ps
module rst_sync (
	input  wire logic clk,
	input  wire logic rst_in_n,
	output logic      rst_out_n
);
	logic meta_r;

	always_ff @(posedge clk or negedge rst_in_n) begin
		if (!rst_in_n) begin
			meta_r    <= 1'b0;
			rst_out_n <= 1'b0;
		end else begin
			meta_r    <= 1'b1;
			rst_out_n <= meta_r;
		end
	end
endmodule // rst_sync

// File: hdl/bit_sync.sv
// two-flop level synchronizer for asynchronous inputs
// assumes din comes from outside the clock domain
`timescale 1ns/1ps
module bit_sync #(
	parameter int W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RST;
			dout   <= RST;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule // bit_sync

// File: tb/rsm_asserts.sv
// port timing checks for the reset and supply supervisor
// assumes a bind onto reset_and_supply_monitor_ctrl, one clock domain
`timescale 1ns/1ps
module rsm_asserts (
	input wire logic       CORE_CLK,
	input wire logic       RST_B,
	input wire logic       EXTERNAL_RESET_PIN_N,
	input wire logic       SUPPLY_STABLE,
	input wire logic       ANA_ABOVE_HIGH,
	input wire logic       POR_MON_EN,
	input wire logic       MON_EN,
	input wire logic       SYS_RST_N,
	input wire logic       HOLD_OUTPUTS,
	input wire logic [1:0] POWER_MODE,
	input wire logic       CPU_WAKE,
	input wire logic       DIGITAL_LOW_VOLTAGE_IRQ,
	input wire logic       ANALOG_LOW_VOLTAGE_IRQ,
	input wire logic       ANALOG_HIGH_VOLTAGE_IRQ,
	input wire logic       WB_CYC_I,
	input wire logic       WB_STB_I,
	input wire logic       WB_ACK_O
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);
	sequence bus_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O && SYS_RST_N;
	endsequence
	sequence hib_held;
		(POWER_MODE == 2'h3) [*2];
	endsequence
	chk_ack_follows: assert property (bus_req |=> WB_ACK_O)
		else $error("ack missing");
	chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	chk_por_width: assert property ($rose(RST_B) |-> (!SYS_RST_N) [*3])
		else $error("reset pulse short");
	chk_release_sync: assert property ($rose(SYS_RST_N) |->
		$past(EXTERNAL_RESET_PIN_N, 2) && $past(SUPPLY_STABLE, 2))
		else $error("release too early");
	chk_pin_holds: assert property ((!EXTERNAL_RESET_PIN_N) [*4] |-> !SYS_RST_N)
		else $error("pin low but no reset");
	chk_por_mon_off: assert property (SYS_RST_N |-> !POR_MON_EN)
		else $error("power-on monitor left on");
	chk_irq_gate: assert property ((!MON_EN) [*2] |-> !(DIGITAL_LOW_VOLTAGE_IRQ
		|| ANALOG_LOW_VOLTAGE_IRQ || ANALOG_HIGH_VOLTAGE_IRQ))
		else $error("irq while monitors off");
	chk_sleep_gate: assert property (POWER_MODE[1] [*2] |-> !MON_EN && !CPU_WAKE)
		else $error("monitors on in low power");
	chk_hib_hold: assert property (hib_held |-> HOLD_OUTPUTS)
		else $error("outputs not held");
	chk_hib_exit: assert property (POWER_MODE == 2'h3 && SYS_RST_N |=>
		POWER_MODE == 2'h3 || !SYS_RST_N)
		else $error("hibernate left without reset");
	chk_high_irq: assert property ((ANA_ABOVE_HIGH && MON_EN) [*5] |->
		ANALOG_HIGH_VOLTAGE_IRQ)
		else $error("high voltage irq missing");
endmodule // rsm_asserts

bind reset_and_supply_monitor_ctrl rsm_asserts rsm_asserts_inst (.CORE_CLK(CORE_CLK),
	.RST_B(RST_B), .EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N), .SUPPLY_STABLE(SUPPLY_STABLE),
	.ANA_ABOVE_HIGH(ANA_ABOVE_HIGH), .POR_MON_EN(POR_MON_EN), .MON_EN(MON_EN),
	.SYS_RST_N(SYS_RST_N), .HOLD_OUTPUTS(HOLD_OUTPUTS), .POWER_MODE(POWER_MODE),
	.CPU_WAKE(CPU_WAKE), .DIGITAL_LOW_VOLTAGE_IRQ(DIGITAL_LOW_VOLTAGE_IRQ),
	.ANALOG_LOW_VOLTAGE_IRQ(ANALOG_LOW_VOLTAGE_IRQ),
	.ANALOG_HIGH_VOLTAGE_IRQ(ANALOG_HIGH_VOLTAGE_IRQ), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O));

// File: tb/reset_source_model.sv
// reset button with pull-up and a slowly ramping supply
// assumes the bench raises power_up once and holds press as a level
`timescale 1ns/1ps
module reset_source_model #(
	parameter int RAMP = 20
) (
	input  wire logic clk,
	input  wire logic power_up,
	input  wire logic press,
	output logic      pin_n,
	output logic      stable
);
	int cnt;
	assign pin_n = !press;
	always_ff @(posedge clk) begin
		if (!power_up)
			cnt <= 0;
		else if (cnt < RAMP)
			cnt <= cnt + 1;
	end
	assign stable = (cnt == RAMP);
endmodule // reset_source_model

// File: tb/tb_reset_and_supply_monitor_ctrl.sv
// self-checking bench for the reset and supply supervisor
// assumes the checker binds itself and the source model is compiled
`timescale 1ns/1ps
module tb_reset_and_supply_monitor_ctrl;
	logic        clk = 0, rst_b = 0, power_up = 0, press = 0, pin_n, stable;
	logic        dig_lo = 0, ana_lo = 0, ana_hi = 0, cyc = 0, stb = 0, we = 0;
	logic        ack, mon_en, sys_n, hold, wake, por_en, osc_en, irq_d, irq_al, irq_ah;
	logic        lost;
	logic [1:0]  pmode;
	logic [3:0]  dsel, asel, t, u, sel = 4'h0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, d;
	int          miscompares = 0, n_compared = 0, lim;

	always #20 clk = ~clk;

	reset_source_model src_inst (.clk(clk), .power_up(power_up), .press(press),
		.pin_n(pin_n), .stable(stable));
	reset_and_supply_monitor_ctrl #(.WAKE_CYC(4)) reset_and_supply_monitor_ctrl_inst (
		.CORE_CLK(clk), .RST_B(rst_b), .EXTERNAL_RESET_PIN_N(pin_n),
		.SUPPLY_STABLE(stable), .DIG_BELOW_TRIP(dig_lo), .ANA_BELOW_TRIP(ana_lo),
		.ANA_ABOVE_HIGH(ana_hi), .DIG_TRIP_SEL(dsel), .ANA_TRIP_SEL(asel),
		.POR_MON_EN(por_en), .OSC_EN(osc_en), .MON_EN(mon_en), .SYS_RST_N(sys_n),
		.HOLD_OUTPUTS(hold), .POWER_MODE(pmode), .CPU_WAKE(wake),
		.DIGITAL_LOW_VOLTAGE_IRQ(irq_d), .ANALOG_LOW_VOLTAGE_IRQ(irq_al),
		.ANALOG_HIGH_VOLTAGE_IRQ(irq_ah), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_DAT_O(rdat), .WB_ACK_O(ack));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [3:0] exp_trip(input logic [3:0] v);
		return (v > 4'hC) ? 4'hC : v;
	endfunction

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		sel <= 4'hF;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		d = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_rst(input logic lvl, input int lim_c);
		int k;
		k = 0;
		while (sys_n !== lvl && k < lim_c) begin
			@(posedge clk);
			k++;
		end
	endtask

	task automatic wait_active(input int lim_c);
		int k;
		k = 0;
		lost = 1'b0;
		while (pmode !== 2'h0 && k < lim_c) begin
			@(posedge clk);
			k++;
			if (sys_n !== 1'b1)
				lost = 1'b1;
		end
	endtask

	task automatic conclude;
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		conclude();
	end

	initial begin
		void'($urandom(95));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		power_up <= 1'b1;
		repeat (2) @(posedge clk);
		chk("ramp reset", {30'h0, por_en, sys_n}, 32'h2);
		wait_rst(1'b1, 60);
		chk("por done", {30'h0, por_en, osc_en}, 32'h1);
		wb(1'b0, 8'h20, 32'h0);
		chk("unmapped", d, 32'h0);
		for (int i = 0; i < 4; i++) begin
			t = (i == 0) ? 4'h0 : (i == 1) ? 4'hC : (i == 2) ? 4'hF : 4'($urandom_range(12, 0));
			u = 4'($urandom_range(15, 0));
			wb(1'b1, 8'h14, {20'h0, u, 4'h0, t});
			wb(1'b0, 8'h14, 32'h0);
			chk("trip reg", d & 32'hF0F, {20'h0, exp_trip(u), 4'h0, exp_trip(t)});
			chk("trip sel", {24'h0, asel, dsel}, {24'h0, exp_trip(u), exp_trip(t)});
		end
		dig_lo <= 1'b1;
		ana_lo <= 1'b1;
		ana_hi <= 1'b1;
		repeat (6) @(posedge clk);
		chk("irqs", {29'h0, irq_d, irq_al, irq_ah}, 32'h7);
		dig_lo <= 1'b0;
		ana_lo <= 1'b0;
		ana_hi <= 1'b0;
		repeat (6) @(posedge clk);
		wb(1'b0, 8'h10, 32'h0);
		chk("irq flags", d & 32'h70, 32'h70);
		wb(1'b1, 8'h10, 32'h70);
		wb(1'b0, 8'h10, 32'h0);
		chk("flags clear", d & 32'h70, 32'h0);
		dig_lo <= 1'b1;
		wb(1'b1, 8'h1C, 32'h12C);
		wb(1'b1, 8'h18, 32'h2);
		repeat (3) @(posedge clk);
		chk("sleep", {28'h0, pmode, wake, mon_en | irq_d}, 32'h8);
		wait_active(2000);
		chk("wake", {30'h0, pmode}, 32'h0);
		repeat (6) @(posedge clk);
		chk("irq after wake", {31'h0, irq_d}, 32'h1);
		dig_lo <= 1'b0;
		wb(1'b1, 8'h00, 32'h1);
		wb(1'b1, 8'h04, 32'h1);
		repeat (5) @(posedge clk);
		chk("sw reset blocked", {31'h0, sys_n}, 32'h1);
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b1, 8'h04, 32'h1);
		wait_rst(1'b0, 20);
		chk("sw reset", {31'h0, sys_n}, 32'h0);
		wait_rst(1'b1, 60);
		wb(1'b0, 8'h10, 32'h0);
		chk("sw flag", {31'h0, d[2]}, 32'h1);
		wb(1'b1, 8'h1C, 32'h32);
		wb(1'b1, 8'h18, 32'h3);
		repeat (2) @(posedge clk);
		chk("hold", {31'h0, hold}, 32'h1);
		wb(1'b1, 8'h18, 32'h0);
		repeat (200) @(posedge clk);
		chk("stay hib", {30'h0, pmode}, 32'h3);
		press <= 1'b1;
		repeat (16) @(posedge clk);
		chk("pin reset", {31'h0, sys_n}, 32'h0);
		press <= 1'b0;
		wait_rst(1'b1, 60);
		chk("after pin", {29'h0, pmode, hold}, 32'h0);
		wb(1'b0, 8'h10, 32'h0);
		chk("pin flag", {31'h0, d[1]}, 32'h1);
		lim = $urandom_range(40, 30);
		wb(1'b1, 8'h08, 32'(lim));
		wb(1'b1, 8'h00, 32'h2);
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b0, 8'h00, 32'h0);
		chk("wdt sticky", {31'h0, d[1]}, 32'h1);
		repeat (4) begin
			repeat (lim / 2) @(posedge clk);
			wb(1'b1, 8'h0C, 32'h0);
		end
		chk("kicked", {31'h0, sys_n}, 32'h1);
		wb(1'b1, 8'h1C, 32'h3E8);
		wb(1'b1, 8'h18, 32'h2);
		wait_active(2000);
		chk("wdt in sleep", {31'h0, lost}, 32'h0);
		wait_rst(1'b0, 2 * lim + 20);
		chk("wdt reset", {31'h0, sys_n}, 32'h0);
		wait_rst(1'b1, 60);
		wb(1'b0, 8'h10, 32'h0);
		chk("wdt flag", {31'h0, d[3]}, 32'h1);
		conclude();
	end
endmodule // tb_reset_and_supply_monitor_ctrl
